//--- acquisition_master.sv
`timescale 1ns/100ps
module acquisition_master (
   // system
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   // rear connector link
   serial_ctrl_if.host_end               link,
   // command port
   input  wire logic                     cmdValid,
   output logic                          cmdReady,
   input  wire logic                     cmdWrite,
   input  wire logic                     cmdSlotZero,
   input  wire logic [4:0]               cmdSlot,
   input  wire serial_ctrl_pkg::reg_sel_type cmdReg,
   input  wire logic [7:0]               cmdData,
   // answer port
   output logic                          rspValid,
   output logic [7:0]                    rspData,
   // scan request
   input  wire logic                     scanPulse
);
   import serial_ctrl_pkg::*;

   typedef enum logic [1:0] {
      HOST_IDLE = 2'b00,
      HOST_XFER = 2'b01
   } host_state_type;

   host_state_type                       state_reg;
   logic [2:0]                           divCnt_reg;
   logic                                 sclk_reg;
   logic                                 riseNow;
   logic                                 fallNow;
   logic [15:0]                          txShift_reg;
   logic [4:0]                           bitCnt_reg;
   logic [7:0]                           rxShift_reg;
   logic                                 serialIn_reg;
   logic                                 dsel_reg;
   logic                                 slot0n_reg;
   logic                                 soSync1_reg;
   logic                                 soSync2_reg;
   logic                                 cmdReady_reg;
   logic                                 rspValid_reg;
   logic [7:0]                           rspData_reg;
   logic                                 scanOut_reg;
   logic [3:0]                           scanCnt_reg;

   // free running divider makes the link clock
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         divCnt_reg <= 3'h0;
         sclk_reg   <= 1'b0;
      end else if (divCnt_reg == 3'(LINK_HALF_CYCLES - 1)) begin
         divCnt_reg <= 3'h0;
         sclk_reg   <= ~sclk_reg;
      end else begin
         divCnt_reg <= divCnt_reg + 3'h1;
      end
   end

   assign riseNow = (divCnt_reg == 3'(LINK_HALF_CYCLES - 1)) & ~sclk_reg;
   assign fallNow = (divCnt_reg == 3'(LINK_HALF_CYCLES - 1)) & sclk_reg;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         soSync1_reg <= 1'b0;
         soSync2_reg <= 1'b0;
      end else begin
         soSync1_reg <= link.serial_out;
         soSync2_reg <= soSync1_reg;
      end
   end

   // lines change on the falling edge, the device samples on the rise
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg    <= HOST_IDLE;
         txShift_reg  <= 16'h0000;
         bitCnt_reg   <= 5'h00;
         rxShift_reg  <= 8'h00;
         serialIn_reg <= 1'b0;
         dsel_reg     <= 1'b0;
         slot0n_reg   <= 1'b1;
         cmdReady_reg <= 1'b0;
         rspValid_reg <= 1'b0;
         rspData_reg  <= 8'h00;
      end else begin
         rspValid_reg <= 1'b0;
         case (state_reg)
            HOST_IDLE: begin
               cmdReady_reg <= 1'b1;
               if (fallNow && cmdValid && cmdReady_reg) begin
                  cmdReady_reg <= 1'b0;
                  state_reg    <= HOST_XFER;
                  txShift_reg  <= {cmdWrite, cmdSlot, cmdReg, cmdData};
                  serialIn_reg <= cmdWrite;
                  dsel_reg     <= 1'b1;
                  slot0n_reg   <= ~cmdSlotZero;
                  bitCnt_reg   <= 5'h00;
               end
            end
            HOST_XFER: begin
               if (riseNow) begin
                  bitCnt_reg <= bitCnt_reg + 5'h01;
                  if (bitCnt_reg >= 5'(ADDR_BITS)) begin
                     rxShift_reg <= {rxShift_reg[6:0], soSync2_reg};
                  end
               end
               if (fallNow) begin
                  if (bitCnt_reg == 5'(FRAME_BITS)) begin
                     state_reg    <= HOST_IDLE;
                     serialIn_reg <= 1'b0;
                     dsel_reg     <= 1'b0;
                     slot0n_reg   <= 1'b1;
                     rspValid_reg <= 1'b1;
                     rspData_reg  <= rxShift_reg;
                  end else begin
                     txShift_reg  <= {txShift_reg[14:0], 1'b0};
                     serialIn_reg <= txShift_reg[14];
                     dsel_reg     <= (bitCnt_reg < 5'(ADDR_BITS));
                  end
               end
            end
            default: state_reg <= HOST_IDLE;
         endcase
      end
   end

   // one scan pulse per request; the caller keeps auto-zero scans apart
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         scanOut_reg <= 1'b0;
         scanCnt_reg <= 4'h0;
      end else if (scanCnt_reg != 4'h0) begin
         scanCnt_reg <= scanCnt_reg - 4'h1;
         scanOut_reg <= (scanCnt_reg != 4'h1);
      end else if (scanPulse) begin
         scanOut_reg <= 1'b1;
         scanCnt_reg <= 4'(SCAN_HIGH_CYCLES);
      end
   end

   assign link.serial_shift_clock  = sclk_reg;
   assign link.serial_in           = serialIn_reg;
   assign link.data_address_select = dsel_reg;
   assign link.slot_zero_select_n  = slot0n_reg;
   assign link.scan_advance_clock  = scanOut_reg;
   assign cmdReady                 = cmdReady_reg;
   assign rspValid                 = rspValid_reg;
   assign rspData                  = rspData_reg;

endmodule

//--- module_serial_control_port.sv
`timescale 1ns/100ps
module module_serial_control_port #(
   parameter logic [7:0]                 MODULE_ID_CODE = 8'h5a,
   parameter logic [4:0]                 MY_SLOT        = 5'h01
) (
   // system
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   // rear connector link
   serial_ctrl_if.device_end             link,
   // chassis return path from other modules, link domain
   input  wire logic                     chassisReturn,
   // analog control outputs
   output logic [2:0]                    channelSel,
   output logic [7:0]                    autoZeroSwitch,
   output logic                          negToReference,
   output logic                          scanEnabled,
   output logic [7:0]                    eepromData
);
   import serial_ctrl_pkg::*;
   // identification value is arbitrary

   // link domain state
   logic                                 rstMeta_reg;
   logic                                 rstLinkN_reg;
   logic [7:0]                           addrShift_reg;
   logic [3:0]                           addrCnt_reg;
   logic                                 addrDone_reg;
   logic [7:0]                           dataShift_reg;
   logic [2:0]                           dataCnt_reg;
   logic                                 mine_reg;
   logic                                 write_reg;
   reg_sel_type                          regSel_reg;
   logic [7:0]                           outShift_reg;
   logic                                 serialOut_reg;
   logic [7:0]                           cfgLink_reg;
   logic [7:0]                           eepLink_reg;
   logic [2:0]                           chanLink_reg;
   reg_sel_type                          lastReg_reg;
   logic                                 commitTog_reg;
   logic [7:0]                           addrNext;
   logic [7:0]                           dataNext;
   logic                                 addrMine;
   logic [7:0]                           readValue;

   // clk domain state
   logic                                 commitSync1_reg;
   logic                                 commitSync2_reg;
   logic                                 commitSeen_reg;
   logic                                 scanSync1_reg;
   logic                                 scanSync2_reg;
   logic                                 scanPrev_reg;
   logic [7:0]                           config_reg;
   logic [7:0]                           eeprom_reg;
   logic [2:0]                           channel_reg;
   logic [2:0]                           channel_next;
   logic [7:0]                           autoZero_reg;
   logic                                 commitEvt;
   logic                                 scanRise;
   logic [3:0]                           linkRstCnt_reg;
   logic                                 linkRstReq_reg;
   logic                                 negRef_reg;

   // register read decode
   function automatic logic [7:0] read_sel(input reg_sel_type sel,
                                           input logic [7:0] cfg,
                                           input logic [7:0] eep,
                                           input logic [2:0] chan);
      logic [7:0] v;
      v = 8'h00;
      case (sel)
         REG_IDENT:   v = MODULE_ID_CODE;
         REG_CONFIG:  v = cfg;
         REG_EEPROM:  v = eep;
         REG_CHANNEL: v = {5'h00, chan};
         default:     v = 8'h00;
      endcase
      return v;
   endfunction

   // next channel with wraparound
   function automatic logic [2:0] next_channel(input logic [2:0] ch);
      logic [2:0] n;
      n = ch + 3'h1;
      if (ch == 3'(CHANNEL_COUNT - 1)) begin
         n = 3'h0;
      end
      return n;
   endfunction

   // the link clock stands still in reset, so the link side is reset
   // by a request that outlasts release, brought over by two flops
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         linkRstCnt_reg <= 4'(LINK_RST_CYCLES);
         linkRstReq_reg <= 1'b1;
      end else if (linkRstCnt_reg != 4'h0) begin
         linkRstCnt_reg <= linkRstCnt_reg - 4'h1;
      end else begin
         linkRstReq_reg <= 1'b0;
      end
   end

   always_ff @(posedge link.serial_shift_clock) begin
      rstMeta_reg  <= ~linkRstReq_reg;
      rstLinkN_reg <= rstMeta_reg;
   end

   assign addrNext = {addrShift_reg[6:0], link.serial_in};
   assign dataNext = {dataShift_reg[6:0], link.serial_in};
   assign addrMine = (addrNext[ADDR_SLOT_HI:ADDR_SLOT_LO] == MY_SLOT);
   assign readValue = read_sel(reg_sel_type'(addrNext[1:0]),
                               cfgLink_reg, eepLink_reg, chanLink_reg);

   // frame tracking: address bits while select high, data while low
   always_ff @(posedge link.serial_shift_clock) begin
      if (!rstLinkN_reg || !link.slot_zero_select_n) begin
         addrCnt_reg   <= 4'h0;
         dataCnt_reg   <= 3'h0;
         addrDone_reg  <= 1'b0;
         addrShift_reg <= 8'h00;
         dataShift_reg <= 8'h00;
         mine_reg      <= 1'b0;
         write_reg     <= 1'b0;
         regSel_reg    <= REG_IDENT;
      end else if (link.data_address_select) begin
         addrShift_reg <= addrNext;
         dataCnt_reg   <= 3'h0;
         if (addrCnt_reg != 4'(ADDR_BITS)) begin
            addrCnt_reg <= addrCnt_reg + 4'h1;
         end
         if (addrCnt_reg == 4'(ADDR_BITS - 1)) begin
            addrDone_reg <= 1'b1;
            mine_reg     <= addrMine;
            write_reg    <= addrNext[ADDR_WRITE_POS];
            regSel_reg   <= reg_sel_type'(addrNext[1:0]);
         end
      end else begin
         addrCnt_reg <= 4'h0;
         if (addrDone_reg) begin
            dataShift_reg <= dataNext;
            dataCnt_reg   <= dataCnt_reg + 3'h1;
            if (dataCnt_reg == 3'(DATA_BITS - 1)) begin
               addrDone_reg <= 1'b0;
               dataCnt_reg  <= 3'h0;
            end
         end
      end
   end

   // writes land at the eighth data bit; identification ignores them
   always_ff @(posedge link.serial_shift_clock) begin
      if (!rstLinkN_reg) begin
         cfgLink_reg   <= CONFIG_RESET;
         eepLink_reg   <= EEPROM_RESET;
         chanLink_reg  <= CHANNEL_RESET;
         lastReg_reg   <= REG_IDENT;
         commitTog_reg <= 1'b0;
      end else if (link.slot_zero_select_n && !link.data_address_select
                   && addrDone_reg && mine_reg && write_reg
                   && dataCnt_reg == 3'(DATA_BITS - 1)) begin
         case (regSel_reg)
            REG_CONFIG:  cfgLink_reg  <= dataNext;
            REG_EEPROM:  eepLink_reg  <= dataNext;
            REG_CHANNEL: chanLink_reg <= dataNext[2:0];
            default:     cfgLink_reg  <= cfgLink_reg;
         endcase
         lastReg_reg   <= regSel_reg;
         commitTog_reg <= ~commitTog_reg;
      end
   end

   // return path: own register when addressed, else the chassis line
   always_ff @(posedge link.serial_shift_clock) begin
      if (!rstLinkN_reg || !link.slot_zero_select_n) begin
         outShift_reg  <= 8'h00;
         serialOut_reg <= 1'b0;
      end else if (link.data_address_select) begin
         if (addrCnt_reg == 4'(ADDR_BITS - 1)) begin
            outShift_reg  <= readValue;
            serialOut_reg <= addrMine ? readValue[7] : chassisReturn;
         end
      end else if (addrDone_reg) begin
         outShift_reg  <= {outShift_reg[6:0], 1'b0};
         serialOut_reg <= mine_reg ? outShift_reg[6] : chassisReturn;
      end
   end

   assign link.serial_out = serialOut_reg;

   // commit toggle and scan edge come over by two flops each
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         commitSync1_reg <= 1'b0;
         commitSync2_reg <= 1'b0;
         commitSeen_reg  <= 1'b0;
         scanSync1_reg   <= 1'b0;
         scanSync2_reg   <= 1'b0;
         scanPrev_reg    <= 1'b0;
      end else begin
         commitSync1_reg <= commitTog_reg;
         commitSync2_reg <= commitSync1_reg;
         commitSeen_reg  <= commitSync2_reg;
         scanSync1_reg   <= link.scan_advance_clock;
         scanSync2_reg   <= scanSync1_reg;
         scanPrev_reg    <= scanSync2_reg;
      end
   end

   assign commitEvt = commitSync2_reg ^ commitSeen_reg;
   assign scanRise  = scanSync2_reg & ~scanPrev_reg;

   // link words hold still for a whole frame after a commit,
   // far longer than the three cycles the toggle takes to arrive
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         config_reg <= CONFIG_RESET;
         eeprom_reg <= EEPROM_RESET;
         negRef_reg <= ~CONFIG_RESET[CFG_NEGREL_POS];
      end else if (commitEvt) begin
         config_reg <= cfgLink_reg;
         eeprom_reg <= eepLink_reg;
         negRef_reg <= ~cfgLink_reg[CFG_NEGREL_POS];
      end
   end

   always_comb begin
      channel_next = channel_reg;
      if (commitEvt && lastReg_reg == REG_CHANNEL) begin
         channel_next = chanLink_reg;
      end else if (scanRise && config_reg[CFG_SCAN_POS]) begin
         channel_next = next_channel(channel_reg);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         channel_reg <= CHANNEL_RESET;
      end else begin
         channel_reg <= channel_next;
      end
   end

   // only the channel in use is shorted, all others stay open
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         autoZero_reg <= 8'h00;
      end else if (config_reg[CFG_AZ_POS]) begin
         autoZero_reg <= 8'h01 << channel_next;
      end else begin
         autoZero_reg <= 8'h00;
      end
   end

   assign channelSel     = channel_reg;
   assign autoZeroSwitch = autoZero_reg;
   assign negToReference = negRef_reg;
   assign scanEnabled    = config_reg[CFG_SCAN_POS];
   assign eepromData     = eeprom_reg;

endmodule

//--- module_serial_control_port_tb.sv
`timescale 1ns/100ps
module module_serial_control_port_tb;
   import serial_ctrl_pkg::*;

   localparam logic [4:0] OWN_SLOT = 5'h01;
   // arbitrary identification value
   localparam logic [7:0] ID_CODE  = 8'h5a;

   logic        clk;
   logic        rst_n;
   logic        cmdValid;
   logic        cmdReady;
   logic        cmdWrite;
   logic        cmdSlotZero;
   logic [4:0]  cmdSlot;
   reg_sel_type cmdReg;
   logic [7:0]  cmdData;
   logic        rspValid;
   logic [7:0]  rspData;
   logic        scanPulse;
   logic        chassisReturn;
   logic [2:0]  channelSel;
   logic [7:0]  autoZeroSwitch;
   logic        negToReference;
   logic        scanEnabled;
   logic [7:0]  eepromData;
   int          n_mismatch = 0;
   int          cmp_count = 0;
   int          cycleCount = 0;

   serial_ctrl_if link ();

   acquisition_master i_acquisition_master (
      .clk (clk), .rst_n (rst_n), .link (link.host_end),
      .cmdValid (cmdValid), .cmdReady (cmdReady), .cmdWrite (cmdWrite),
      .cmdSlotZero (cmdSlotZero), .cmdSlot (cmdSlot), .cmdReg (cmdReg),
      .cmdData (cmdData), .rspValid (rspValid), .rspData (rspData),
      .scanPulse (scanPulse));

   module_serial_control_port #(.MODULE_ID_CODE (ID_CODE),
      .MY_SLOT (OWN_SLOT)) i_module_serial_control_port (
      .clk (clk), .rst_n (rst_n), .link (link.device_end),
      .chassisReturn (chassisReturn), .channelSel (channelSel),
      .autoZeroSwitch (autoZeroSwitch), .negToReference (negToReference),
      .scanEnabled (scanEnabled), .eepromData (eepromData));

   serial_ctrl_monitor i_serial_ctrl_monitor (
      .clk (clk), .rst_n (rst_n),
      .serial_shift_clock (link.serial_shift_clock),
      .serial_in (link.serial_in), .serial_out (link.serial_out),
      .data_address_select (link.data_address_select),
      .slot_zero_select_n (link.slot_zero_select_n),
      .scan_advance_clock (link.scan_advance_clock));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // holds the request until ready drops, so a take is never missed
   task automatic xfer(input logic w, input logic z, input logic [4:0] s,
                       input reg_sel_type r, input logic [7:0] d,
                       output logic [7:0] q);
      int n;
      n = 0;
      while (cmdReady !== 1'b1 && n < 300) begin
         @(posedge clk);
         n++;
      end
      cmdWrite <= w;
      cmdSlotZero <= z;
      cmdSlot <= s;
      cmdReg <= r;
      cmdData <= d;
      cmdValid <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (cmdReady !== 1'b0 && n < 300);
      cmdValid <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (rspValid !== 1'b1 && n < 600);
      q = rspData;
      if (n >= 600) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: frame got no answer", $time);
      end
      repeat (6) @(posedge clk);
   endtask

   task automatic pulse_scan;
      scanPulse <= 1'b1;
      @(posedge clk);
      scanPulse <= 1'b0;
      repeat (20) @(posedge clk);
   endtask

   // change only just after a link rise; the return path may be unclocked
   task automatic set_return(input logic v);
      while (link.serial_shift_clock !== 1'b0) @(posedge clk);
      while (link.serial_shift_clock !== 1'b1) @(posedge clk);
      chassisReturn <= v;
      @(posedge clk);
   endtask

   task automatic t_reset_state;
      check({7'h00, negToReference}, 8'h01);
      check({5'h00, channelSel}, 8'h00);
      check(autoZeroSwitch, 8'h00);
      check({7'h00, scanEnabled}, 8'h00);
      check(eepromData, 8'h00);
   endtask

   task automatic t_ident;
      logic [7:0] q;
      xfer(1'b0, 1'b0, OWN_SLOT, REG_IDENT, 8'h00, q);
      check(q, ID_CODE);
      xfer(1'b1, 1'b0, OWN_SLOT, REG_IDENT, 8'h3c, q);
      xfer(1'b0, 1'b0, OWN_SLOT, REG_IDENT, 8'h00, q);
      check(q, ID_CODE);
   endtask

   task automatic t_regs;
      logic [7:0] q;
      xfer(1'b1, 1'b0, OWN_SLOT, REG_EEPROM, 8'ha5, q);
      check(eepromData, 8'ha5);
      xfer(1'b0, 1'b0, OWN_SLOT, REG_EEPROM, 8'h00, q);
      check(q, 8'ha5);
      xfer(1'b1, 1'b0, OWN_SLOT, REG_CHANNEL, 8'h03, q);
      check({5'h00, channelSel}, 8'h03);
      xfer(1'b1, 1'b0, OWN_SLOT, REG_CONFIG, 8'h06, q);
      check(autoZeroSwitch, 8'h08);
      check({7'h00, negToReference}, 8'h00);
      xfer(1'b0, 1'b0, OWN_SLOT, REG_CONFIG, 8'h00, q);
      check(q, 8'h06);
   endtask

   task automatic t_scan;
      logic [7:0] q;
      logic [2:0] e;
      pulse_scan();
      check({5'h00, channelSel}, 8'h03);
      xfer(1'b1, 1'b0, OWN_SLOT, REG_CONFIG, 8'h01, q);
      check(autoZeroSwitch, 8'h00);
      check({7'h00, negToReference}, 8'h01);
      xfer(1'b1, 1'b0, OWN_SLOT, REG_CHANNEL, 8'h06, q);
      for (int i = 0; i < 3; i++) begin
         pulse_scan();
         e = 3'h6 + 3'(i + 1);
         check({5'h00, channelSel}, {5'h00, e});
      end
      xfer(1'b0, 1'b0, OWN_SLOT, REG_CHANNEL, 8'h00, q);
      check(q, 8'h06);
   endtask

   task automatic t_foreign;
      logic [7:0] q;
      xfer(1'b1, 1'b1, OWN_SLOT, REG_CONFIG, 8'h00, q);
      check(q, 8'h00);
      check({7'h00, scanEnabled}, 8'h01);
      set_return(1'b1);
      xfer(1'b0, 1'b0, 5'h02, REG_IDENT, 8'h00, q);
      check(q, 8'hff);
      xfer(1'b1, 1'b0, 5'h02, REG_CONFIG, 8'h00, q);
      check({7'h00, scanEnabled}, 8'h01);
      set_return(1'b0);
      xfer(1'b0, 1'b0, 5'h02, REG_IDENT, 8'h00, q);
      check(q, 8'h00);
   endtask

   always @(posedge clk) begin
      cycleCount <= cycleCount + 1;
      if (cycleCount == 12000) begin
         n_mismatch++;
         complete_run();
      end
   end

   initial begin
      rst_n = 1'b0;
      cmdValid = 1'b0;
      cmdWrite = 1'b0;
      cmdSlotZero = 1'b0;
      cmdSlot = 5'h00;
      cmdReg = REG_IDENT;
      cmdData = 8'h00;
      scanPulse = 1'b0;
      chassisReturn = 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      // the link side leaves reset about three link periods later
      repeat (24) @(posedge clk);
      t_reset_state();
      t_ident();
      t_regs();
      t_scan();
      t_foreign();
      complete_run();
   end
endmodule

//--- serial_ctrl_if.sv
`timescale 1ns/100ps
interface serial_ctrl_if;
   logic serial_shift_clock;
   logic serial_in;
   logic serial_out;
   logic data_address_select;
   logic slot_zero_select_n;
   logic scan_advance_clock;

   modport device_end (
      input  serial_shift_clock,
      input  serial_in,
      output serial_out,
      input  data_address_select,
      input  slot_zero_select_n,
      input  scan_advance_clock
   );

   modport host_end (
      output serial_shift_clock,
      output serial_in,
      input  serial_out,
      output data_address_select,
      output slot_zero_select_n,
      output scan_advance_clock
   );
endinterface

//--- serial_ctrl_monitor.sv
`timescale 1ns/100ps
module serial_ctrl_monitor (
   // system
   input  wire logic clk,
   input  wire logic rst_n,
   // link
   input  wire logic serial_shift_clock,
   input  wire logic serial_in,
   input  wire logic serial_out,
   input  wire logic data_address_select,
   input  wire logic slot_zero_select_n,
   input  wire logic scan_advance_clock
);
   import serial_ctrl_pkg::*;

   localparam int ADDR_SPAN = ADDR_BITS * 2 * LINK_HALF_CYCLES;
   localparam int MIN_GAP   = ADDR_SPAN + 2 * LINK_HALF_CYCLES;

   logic [7:0]    addrHigh_reg;
   logic [7:0]    idleLow_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   always_ff @(posedge clk) begin
      if (!rst_n || !data_address_select)
         addrHigh_reg <= 8'h00;
      else
         addrHigh_reg <= addrHigh_reg + 8'h01;
   end

   // starts saturated so the first frame after reset is not flagged
   always_ff @(posedge clk) begin
      if (!rst_n)
         idleLow_reg <= 8'hff;
      else if (data_address_select)
         idleLow_reg <= 8'h00;
      else if (idleLow_reg != 8'hff)
         idleLow_reg <= idleLow_reg + 8'h01;
   end

   a_link_clock_period: assert property (
      $rose(serial_shift_clock) |-> serial_shift_clock[*4]
         ##1 !serial_shift_clock[*4] ##1 serial_shift_clock)
      else $error("link clock period wrong");
   a_input_on_fall: assert property (
      $changed(serial_in) |-> $fell(serial_shift_clock))
      else $error("serial input moved off the falling edge");
   a_select_on_fall: assert property (
      $changed(data_address_select) |-> $fell(serial_shift_clock))
      else $error("address qualifier moved off the falling edge");
   a_address_length: assert property (
      $fell(data_address_select) |-> addrHigh_reg == 8'(ADDR_SPAN))
      else $error("address phase not eight bits long");
   a_frame_gap: assert property (
      $rose(data_address_select) |-> idleLow_reg >= 8'(MIN_GAP))
      else $error("address started before data byte ended");
   a_slot_zero_quiet: assert property (
      !slot_zero_select_n[*8] ##1 !slot_zero_select_n |-> !serial_out)
      else $error("return line active during slot zero stream");
   a_output_after_rise: assert property (
      $changed(serial_out) |-> serial_shift_clock)
      else $error("return line moved while link clock low");
   a_scan_pulse_width: assert property (
      $rose(scan_advance_clock) |-> scan_advance_clock[*8]
         ##1 scan_advance_clock ##1 scan_advance_clock
         ##1 !scan_advance_clock)
      else $error("scan pulse width wrong");

   c_scan: cover property ($rose(scan_advance_clock));
   c_slot_zero: cover property ($fell(slot_zero_select_n));
   c_frame: cover property ($fell(data_address_select));
endmodule

//--- serial_ctrl_pkg.sv
// Behaviour
// - host programs every slot over serial_in
// - cabled module returns data on serial_out
// - data_address_select marks address or data bits
// - slot_zero_select_n low: stream not ours
// - scan clock rising edge advances channel
// - both serial lines shift on serial_shift_clock
// - after reset negative output ties to reference
// - per-channel auto-zero switch shorts input
// - auto-zero readings scanned on their own
// - address decoder picks one of four registers
// - channel register: single or scan start
// - read-only identification register
package serial_ctrl_pkg;

   // frame layout: 8 address bits then 8 data bits, msb first
   localparam int            ADDR_BITS      = 8;
   localparam int            DATA_BITS      = 8;
   localparam int            FRAME_BITS     = 16;
   localparam int            ADDR_WRITE_POS = 7;
   localparam int            ADDR_SLOT_HI   = 6;
   localparam int            ADDR_SLOT_LO   = 2;
   localparam int            SLOT_W         = 5;

   // register selector carried in the address byte
   typedef enum logic [1:0] {
      REG_IDENT   = 2'b00,
      REG_CONFIG  = 2'b01,
      REG_EEPROM  = 2'b10,
      REG_CHANNEL = 2'b11
   } reg_sel_type;

   // configuration register fields
   localparam int            CFG_SCAN_POS   = 0;
   localparam int            CFG_AZ_POS     = 1;
   localparam int            CFG_NEGREL_POS = 2;
   localparam logic [7:0]    CONFIG_RESET   = 8'h00;
   localparam logic [7:0]    EEPROM_RESET   = 8'h00;
   localparam logic [2:0]    CHANNEL_RESET  = 3'h0;
   localparam int            CHANNEL_COUNT  = 8;
   // link side reset outlasts release by at least one link period
   localparam int            LINK_RST_CYCLES = 8;

   // timing
   localparam int            CLK_PERIOD_NS  = 10;
   localparam int            LINK_HALF_NS   = 40;
   localparam int            LINK_HALF_CYCLES =
      (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int            SCAN_HIGH_NS   = 100;
   localparam int            SCAN_HIGH_CYCLES =
      (SCAN_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage
